/* File: hw/esc_mode_consts.svh */
// constants for the serial escape and command-mode controller
`ifndef ESC_MODE_CONSTS_SVH
`define ESC_MODE_CONSTS_SVH

// =====================================================================
// timing
`define CLK_HZ 32'h017D_7840
`define MS_PER_S 32'h0000_03E8
`define CT_UNIT_MS 24'h00_0064

// =====================================================================
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_GUARD 8'h04
`define REG_ESC 8'h08
`define REG_CTMO 8'h0C
`define REG_STAT 8'h10

// =====================================================================
// field positions and reset values
`define CTRL_API_BIT 0
`define CTRL_SPI_BIT 1
`define GT_RST 16'h03E8
`define CC_RST 8'h2B
`define CT_RST 16'h0064

// =====================================================================
// characters
`define CH_A 8'h41
`define CH_T 8'h54
`define CH_X 8'h58
`define CH_C 8'h43
`define CH_N 8'h4E
`define CH_G 8'h47
`define CH_P 8'h50
`define CH_0 8'h30
`define CH_CR 8'h0D
`define CH_COMMA 8'h2C
`define CH_SPACE 8'h20
`define CH_O 8'h4F
`define CH_K 8'h4B
`define CH_E 8'h45
`define CH_R 8'h52
`define OK_LAST 3'h2
`define ERR_LAST 3'h5

`endif

/* File: hw/esc_mode_pkg.sv */
// types shared by the escape and command-mode controller
package esc_mode_pkg;

  // top-level operating state
  typedef enum logic [4:0] {
    ST_PASS = 5'h01,
    ST_ESC = 5'h02,
    ST_POST = 5'h04,
    ST_FLUSH = 5'h08,
    ST_CMD = 5'h10
  } mode_t;

  // command line parser position
  typedef enum logic [5:0] {
    P_A = 6'h01,
    P_T = 6'h02,
    P_ID1 = 6'h04,
    P_ID2 = 6'h08,
    P_PAR = 6'h10,
    P_SKIP = 6'h20
  } parse_t;

  typedef struct packed {
    mode_t st;
    parse_t ps;
    logic [15:0] rdata;
    logic api;
    logic spi_sel;
    logic [15:0] gt;
    logic [7:0] cc;
    logic [15:0] ct;
    logic [15:0] sil;
    logic [23:0] idle;
    logic [1:0] esc_n;
    logic pend_v;
    logic [7:0] pend;
    logic rf_v;
    logic [7:0] rf_d;
    logic tx_v;
    logic [7:0] tx_d;
    logic srx_rdy;
    logic rrx_rdy;
    logic [1:0] hdr_n;
    logic [15:0] hdr_src;
    logic [7:0] hdr_dat;
    logic rep_on;
    logic rep_err;
    logic [2:0] rep_i;
    logic exit_pend;
    logic [7:0] id1;
    logic [7:0] id2;
    logic [15:0] par;
    logic [2:0] par_n;
    logic bad;
    logic in_cmd;
  } ctl_t;

endpackage

/* File: hw/ms_tick_gen.sv */
// millisecond enable pulse divider
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = 25000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // one-cycle pulse per millisecond
  output logic o_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_t;

  tick_t q;
  tick_t d;

  // wrap counter, pulse on the wrap
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 16'(CYCLES - 1)) begin
      d.cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;
endmodule

/* File: hw/esc_mode_ctrl.sv */
// serial escape detection, command interpreter and data path steering
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "esc_mode_consts.svh"
module esc_mode_ctrl import esc_mode_pkg::*; #(
  parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // serial side, bytes from host
  input wire logic i_ser_rx_valid,
  input wire logic [7:0] i_ser_rx_data,
  input wire logic i_ser_rx_spi,
  output logic o_ser_rx_ready,
  // serial side, bytes to host
  output logic o_ser_tx_valid,
  output logic [7:0] o_ser_tx_data,
  input wire logic i_ser_tx_ready,
  // radio side, bytes to transmit
  output logic o_rf_tx_valid,
  output logic [7:0] o_rf_tx_data,
  input wire logic i_rf_tx_ready,
  // radio side, received bytes
  input wire logic i_rf_rx_valid,
  input wire logic [7:0] i_rf_rx_data,
  input wire logic i_rf_rx_first,
  input wire logic [15:0] i_rf_rx_src,
  output logic o_rf_rx_ready,
  // status and long command hint
  input wire logic i_long_busy,
  output logic o_cmd_mode,
  output logic o_api_mode
);

  // ===================================================================
  // helpers

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  // nibble value of a hex digit, bit 4 flags a valid digit
  function automatic logic [4:0] hexval(input logic [7:0] c);
    logic [7:0] u;
    u = upcase(c);
    hexval = 5'h00;
    if (u >= 8'h30 && u <= 8'h39) begin
      hexval = {1'b1, 4'(u - 8'h30)};
    end else if (u >= 8'h41 && u <= 8'h46) begin
      hexval = {1'b1, 4'(u - 8'h37)};
    end
  endfunction

  function automatic logic [23:0] ct_ms(input logic [15:0] ct);
    ct_ms = 24'(ct * `CT_UNIT_MS);
  endfunction

  function automatic logic [7:0] reply_char(input logic err, input logic [2:0] i);
    logic [7:0] c;
    c = `CH_CR;
    if (!err) begin
      unique case (i)
        3'h0: c = `CH_O;
        3'h1: c = `CH_K;
        default: c = `CH_CR;
      endcase
    end else begin
      unique case (i)
        3'h0: c = `CH_E;
        3'h1: c = `CH_R;
        3'h2: c = `CH_R;
        3'h3: c = `CH_O;
        3'h4: c = `CH_R;
        default: c = `CH_CR;
      endcase
    end
    reply_char = c;
  endfunction

  // ===================================================================
  // state

  ctl_t q;
  ctl_t d;
  logic tick;
  logic srx;
  logic rrx;
  logic esc_src_ok;
  logic [7:0] ch;
  logic [4:0] hv;

  ms_tick_gen #(.CYCLES(MS_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .o_tick(tick)
  );

  assign srx = i_ser_rx_valid && q.srx_rdy;
  assign rrx = i_rf_rx_valid && q.rrx_rdy;
  assign esc_src_ok = !i_ser_rx_spi || q.spi_sel;
  assign ch = upcase(i_ser_rx_data);
  assign hv = hexval(i_ser_rx_data);

  // ===================================================================
  // next state
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    // silence measured from the last byte taken, saturating
    if (tick) begin
      if (q.sil != 16'hFFFF) d.sil = q.sil + 16'h0001;
      if (q.idle != 24'hFF_FFFF) d.idle = q.idle + 24'h00_0001;
    end
    if (srx) begin
      d.sil = 16'h0000;
      d.idle = 24'h00_0000;
    end
    if (q.tx_v && i_ser_tx_ready) d.tx_v = 1'b0;
    if (q.rf_v && i_rf_tx_ready) d.rf_v = 1'b0;

    // register writes; honoured in every mode, even with a long command busy
    if (i_wr) begin
      unique case (i_addr)
        `REG_CTRL: begin
          d.api = i_wdata[`CTRL_API_BIT];
          d.spi_sel = i_wdata[`CTRL_SPI_BIT];
        end
        `REG_GUARD: d.gt = i_wdata;
        `REG_ESC: d.cc = i_wdata[7:0];
        `REG_CTMO: d.ct = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        `REG_CTRL: d.rdata = {14'h0000, q.spi_sel, q.api};
        `REG_GUARD: d.rdata = q.gt;
        `REG_ESC: d.rdata = {8'h00, q.cc};
        `REG_CTMO: d.rdata = q.ct;
        `REG_STAT: d.rdata = {11'h000, q.st};
        default: d.rdata = 16'h0000;
      endcase
    end

    // escape detection and command interpretation
    unique case (q.st)
      ST_PASS: begin
        if (srx) begin
          if (i_ser_rx_data == q.cc && q.sil >= q.gt && esc_src_ok) begin
            d.esc_n = 2'h1;
            d.st = ST_ESC;
          end else begin
            d.rf_v = 1'b1;
            d.rf_d = i_ser_rx_data;
          end
        end
      end
      ST_ESC: begin
        if (srx) begin
          if (i_ser_rx_data == q.cc && esc_src_ok) begin
            d.esc_n = q.esc_n + 2'h1;
            if (q.esc_n == 2'h2) d.st = ST_POST;
          end else begin
            d.pend_v = 1'b1;
            d.pend = i_ser_rx_data;
            d.st = ST_FLUSH;
          end
        end
      end
      ST_POST: begin
        if (srx) begin
          d.pend_v = 1'b1;
          d.pend = i_ser_rx_data;
          d.st = ST_FLUSH;
        end else if (q.sil >= q.gt) begin
          d.st = ST_CMD;
          d.esc_n = 2'h0;
          d.rep_on = 1'b1;
          d.rep_err = 1'b0;
          d.rep_i = 3'h0;
          d.ps = P_A;
          d.bad = 1'b0;
          d.idle = 24'h00_0000;
        end
      end
      ST_FLUSH: begin
        // failed sequence goes out as plain data
        if (!d.rf_v) begin
          if (q.esc_n != 2'h0) begin
            d.rf_v = 1'b1;
            d.rf_d = q.cc;
            d.esc_n = q.esc_n - 2'h1;
          end else if (q.pend_v) begin
            d.rf_v = 1'b1;
            d.rf_d = q.pend;
            d.pend_v = 1'b0;
          end else begin
            d.st = ST_PASS;
          end
        end
      end
      ST_CMD: begin
        if (srx) begin
          // bytes are consumed here and never reach the radio
          unique case (q.ps)
            P_A: begin
              if (ch == `CH_A) d.ps = P_T;
              else if (ch != `CH_CR) d.ps = P_SKIP;
            end
            P_T: d.ps = (ch == `CH_T) ? P_ID1 : P_SKIP;
            P_ID1: begin
              d.id1 = ch;
              d.ps = P_ID2;
            end
            P_ID2: begin
              d.id2 = ch;
              d.par = 16'h0000;
              d.par_n = 3'h0;
              d.ps = P_PAR;
            end
            P_PAR: begin
              if (ch == `CH_CR || ch == `CH_COMMA) begin
                // execute the command just parsed
                if (i_long_busy) begin
                  d.bad = 1'b1;
                end else if (q.id1 == `CH_C && q.id2 == `CH_N) begin
                  d.exit_pend = 1'b1;
                end else if (q.id1 == `CH_G && q.id2 == `CH_T) begin
                  if (q.par_n != 3'h0) d.gt = q.par;
                end else if (q.id1 == `CH_C && q.id2 == `CH_C) begin
                  if (q.par_n != 3'h0) d.cc = q.par[7:0];
                end else if (q.id1 == `CH_C && q.id2 == `CH_T) begin
                  if (q.par_n != 3'h0) d.ct = q.par;
                end else if (q.id1 == `CH_A && q.id2 == `CH_P) begin
                  if (q.par > 16'h0001) d.bad = 1'b1;
                  else if (q.par_n != 3'h0) d.api = q.par[0];
                end else begin
                  d.bad = 1'b1;
                end
                d.ps = (ch == `CH_COMMA) ? P_ID1 : P_A;
                if (ch == `CH_CR) begin
                  d.rep_on = 1'b1;
                  d.rep_err = d.bad;
                  d.rep_i = 3'h0;
                  d.bad = 1'b0;
                end
              end else if (ch == `CH_X && q.par_n == 3'h1 && q.par == 16'h0000) begin
                d.par_n = 3'h0;
              end else if (hv[4] && q.par_n != 3'h4) begin
                d.par = {q.par[11:0], hv[3:0]};
                d.par_n = q.par_n + 3'h1;
              end else if (ch != `CH_SPACE) begin
                d.ps = P_SKIP;
              end
            end
            P_SKIP: begin
              // garbled line, one error answer at its end
              if (ch == `CH_CR) begin
                d.rep_on = 1'b1;
                d.rep_err = 1'b1;
                d.rep_i = 3'h0;
                d.bad = 1'b0;
                d.exit_pend = 1'b0;
                d.ps = P_A;
              end
            end
            default: d.ps = P_A;
          endcase
        end else if (!q.rep_on && q.idle >= ct_ms(q.ct)) begin
          d.st = ST_PASS;
          d.ps = P_A;
        end
      end
      default: d.st = ST_PASS;
    endcase

    // radio bytes toward the host, framed mode adds the source first
    if (rrx) begin
      if (q.api && i_rf_rx_first) begin
        d.hdr_n = 2'h3;
        d.hdr_src = i_rf_rx_src;
        d.hdr_dat = i_rf_rx_data;
      end else begin
        d.tx_v = 1'b1;
        d.tx_d = i_rf_rx_data;
      end
    end
    if (q.hdr_n != 2'h0 && !d.tx_v) begin
      d.tx_v = 1'b1;
      d.tx_d = (q.hdr_n == 2'h3) ? q.hdr_src[15:8] :
               (q.hdr_n == 2'h2) ? q.hdr_src[7:0] : q.hdr_dat;
      d.hdr_n = q.hdr_n - 2'h1;
    end else if (q.rep_on && !d.tx_v) begin
      d.tx_v = 1'b1;
      d.tx_d = reply_char(q.rep_err, q.rep_i);
      d.rep_i = q.rep_i + 3'h1;
      if (q.rep_i == (q.rep_err ? `ERR_LAST : `OK_LAST)) begin
        d.rep_on = 1'b0;
        if (q.exit_pend) begin
          d.exit_pend = 1'b0;
          d.st = ST_PASS;
          d.ps = P_A;
        end
      end
    end

    // flow control: only take a byte when its outlet is free next cycle
    d.srx_rdy = !d.rf_v && !d.rep_on && !d.exit_pend && d.st != ST_FLUSH;
    d.rrx_rdy = d.st != ST_CMD && !d.tx_v && d.hdr_n == 2'h0 && !d.rep_on;
    d.in_cmd = d.st == ST_CMD;
  end

  // register the whole state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      q.st <= ST_PASS;
      q.ps <= P_A;
      q.gt <= `GT_RST;
      q.cc <= `CC_RST;
      q.ct <= `CT_RST;
    end else begin
      q <= d;
    end
  end

  // outputs, all straight from flops
  assign o_rdata = q.rdata;
  assign o_ser_rx_ready = q.srx_rdy;
  assign o_ser_tx_valid = q.tx_v;
  assign o_ser_tx_data = q.tx_d;
  assign o_rf_tx_valid = q.rf_v;
  assign o_rf_tx_data = q.rf_d;
  assign o_rf_rx_ready = q.rrx_rdy;
  assign o_cmd_mode = q.in_cmd;
  assign o_api_mode = q.api;

  // ===================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_pass_forward: assert property ((srx && q.st == ST_PASS && i_ser_rx_data != q.cc)
    |=> o_rf_tx_valid && o_rf_tx_data == $past(i_ser_rx_data)) else $error("byte not forwarded");
  a_rf_to_host: assert property ((rrx && !q.api)
    |=> o_ser_tx_valid && o_ser_tx_data == $past(i_rf_rx_data)) else $error("radio byte lost");
  a_no_fwd_cmd: assert property ((srx && q.st == ST_CMD) |=> !$rose(o_rf_tx_valid))
    else $error("command byte reached radio");
  a_guard_needed: assert property ((srx && q.st == ST_PASS && q.sil < q.gt)
    |=> q.st == ST_PASS) else $error("escape taken without guard");
  a_spi_gate: assert property ((srx && q.st == ST_PASS && i_ser_rx_spi && !q.spi_sel)
    |=> q.st == ST_PASS) else $error("spi escape accepted");
  a_post_cancel: assert property ((srx && q.st == ST_POST) |=> q.st == ST_FLUSH)
    else $error("trailing byte did not cancel");
  a_enter_reply: assert property ($rose(q.st == ST_CMD) && !o_ser_tx_valid
    && q.hdr_n == 2'h0 |-> q.rep_on && !q.rep_err
    ##1 (o_ser_tx_valid && o_ser_tx_data == `CH_O)) else $error("no OK on entry");
  a_idle_exit: assert property ((q.st == ST_CMD && !q.rep_on && !srx
    && q.idle >= ct_ms(q.ct)) |=> q.st == ST_PASS) else $error("timeout ignored");
  a_src_prefix: assert property ((rrx && q.api && i_rf_rx_first)
    |=> q.hdr_n == 2'h3 && q.hdr_src == $past(i_rf_rx_src)) else $error("source not kept");
  a_flush_held: assert property ((srx && q.st == ST_ESC && i_ser_rx_data != q.cc)
    |=> q.st == ST_FLUSH && q.esc_n == $past(q.esc_n)) else $error("held escapes dropped");

  c_enter_cmd: cover property ($rose(q.st == ST_CMD));
  c_flush: cover property (q.st == ST_FLUSH ##1 q.st == ST_PASS);
  c_exit_cn: cover property (q.exit_pend ##[1:8] q.st == ST_PASS);
  c_api_hdr: cover property (q.hdr_n == 2'h3);
endmodule

/* File: test/host_serial_model.sv */
// host-side serial partner: feeds bytes to the block and accepts its replies
`timescale 1ns/1ps
module host_serial_model (
  // clock
  input wire logic i_clk,
  // reply pacing: high makes the host take a byte only every other cycle
  input wire logic i_slow,
  // bytes toward the block
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_spi,
  input wire logic i_ready,
  // bytes from the block
  output logic o_tx_ready
);
  logic ph_q = 1'b0;

  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_spi = 1'b0;
  end

  // a slow host stalls the reply stream half of the time
  always @(posedge i_clk) begin
    ph_q <= ~ph_q;
  end
  assign o_tx_ready = ~i_slow | ph_q;

  // one byte held until taken; released data is scrambled, never left stale
  task automatic send(input logic [7:0] b, input logic spi);
    int n;
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_data <= b;
    o_spi <= spi;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ready !== 1'b1 && n < 200);
    o_valid <= 1'b0;
    o_data <= ~b;
  endtask
endmodule

/* File: test/serial_escape_mode_control_test.sv */
// self-checking bench for the serial escape and command-mode controller
`timescale 1ns/1ps
`include "esc_mode_consts.svh"
module serial_escape_mode_control_test;
  logic i_clk, i_nrst, i_wr, i_rd, rd_q, slow;
  logic [7:0] i_addr, h_data, o_ser_tx_data, o_rf_tx_data, i_rf_rx_data, b;
  logic [15:0] i_wdata, o_rdata, i_rf_rx_src;
  logic h_valid, h_spi, h_ready, h_tx_ready, o_ser_tx_valid, o_rf_tx_valid;
  logic i_rf_tx_ready, i_rf_rx_valid, i_rf_rx_first, o_rf_rx_ready;
  logic o_cmd_mode, o_api_mode, busy;
  logic [15:0] exp_w;
  int errors, comparisons, cycles, seed;
  logic [7:0] rf_q[$];
  logic [7:0] ser_q[$];
  logic [15:0] rd_exp[$];

  // ==========================================================
  // design and host partner
  esc_mode_ctrl #(.MS_CYCLES(4)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ser_rx_valid(h_valid), .i_ser_rx_data(h_data), .i_ser_rx_spi(h_spi),
    .o_ser_rx_ready(h_ready), .o_ser_tx_valid(o_ser_tx_valid),
    .o_ser_tx_data(o_ser_tx_data), .i_ser_tx_ready(h_tx_ready),
    .o_rf_tx_valid(o_rf_tx_valid), .o_rf_tx_data(o_rf_tx_data),
    .i_rf_tx_ready(i_rf_tx_ready), .i_rf_rx_valid(i_rf_rx_valid),
    .i_rf_rx_data(i_rf_rx_data), .i_rf_rx_first(i_rf_rx_first),
    .i_rf_rx_src(i_rf_rx_src), .o_rf_rx_ready(o_rf_rx_ready), .i_long_busy(busy),
    .o_cmd_mode(o_cmd_mode), .o_api_mode(o_api_mode));
  host_serial_model host (.i_clk(i_clk), .i_slow(slow), .o_valid(h_valid),
    .o_data(h_data), .o_spi(h_spi), .i_ready(h_ready), .o_tx_ready(h_tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // output watcher: each result takes the oldest note; x means none was due
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    i_rf_tx_ready <= $random(seed) > 0;  // radio stalls at random
    cycles++;
    if (rd_q === 1'b1) begin
      exp_w = rd_exp.size() ? rd_exp.pop_front() : 16'hxxxx;
      check(o_rdata, exp_w);
    end
    if (o_rf_tx_valid === 1'b1 && i_rf_tx_ready === 1'b1) begin
      exp_w = rf_q.size() ? {8'h00, rf_q.pop_front()} : 16'hxxxx;
      check({8'h00, o_rf_tx_data}, exp_w);
    end
    if (o_ser_tx_valid === 1'b1 && h_tx_ready === 1'b1) begin
      exp_w = ser_q.size() ? {8'h00, ser_q.pop_front()} : 16'hxxxx;
      check({8'h00, o_ser_tx_data}, exp_w);
    end
    if (cycles == 30000) begin
      errors++;
      results();
    end
  end

  // ==========================================================
  // drivers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_exp.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  task automatic rf_in(input logic [7:0] d, input logic f, input logic [15:0] s);
    int n;
    @(posedge i_clk);
    i_rf_rx_valid <= 1'b1;
    i_rf_rx_data <= d;
    i_rf_rx_first <= f;
    i_rf_rx_src <= s;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_rf_rx_ready !== 1'b1 && n < 200);
    i_rf_rx_valid <= 1'b0;
    i_rf_rx_data <= ~d;
    i_rf_rx_src <= ~s;
  endtask

  task automatic line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      host.send(s[i], 1'b0);
    end
  endtask

  task automatic expect_ser(input string s);
    for (int i = 0; i < s.len(); i++) begin
      ser_q.push_back(s[i]);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // bounded wait on the mode flag, sampled on the falling edge where it is settled
  task automatic wait_mode(input logic m);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_cmd_mode !== m && n < 200);
    check({15'h0000, o_cmd_mode}, {15'h0000, m});
  endtask

  // guard time is set to 5 ms = 20 cycles, later 6 ms = 24 cycles, so 40 idle cycles clear it
  task automatic escape(input logic [7:0] c, input logic spi);
    idle(40);
    repeat (3) host.send(c, spi);
    idle(40);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 56137;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    {i_nrst, i_wr, i_rd, slow, i_rf_rx_valid, i_rf_rx_first, busy} = 7'h00;
    {i_addr, i_wdata, i_rf_rx_data, i_rf_rx_src} = 48'h0000_0000_0000;
    idle(20);
    i_nrst <= 1'b1;
    idle(2);
    rd(`REG_CTRL, 16'h0000);
    rd(`REG_GUARD, 16'h03E8);
    rd(`REG_ESC, 16'h002B);
    rd(`REG_CTMO, 16'h0064);
    rd(`REG_STAT, 16'h0001);
    rd(8'hFC, 16'h0000);
    // random pass-through payload, never the escape character
    for (int i = 0; i < 8; i++) begin
      b = $random(seed);
      if (b == 8'h2B) b = 8'h2A;
      rf_q.push_back(b);
      host.send(b, 1'b0);
    end
    slow <= 1'b1;
    ser_q.push_back(8'h5A);
    rf_in(8'h5A, 1'b1, 16'h1234);
    wr(`REG_GUARD, 16'h0005);
    wr(`REG_ESC, 16'h0031);
    wr(`REG_CTMO, 16'h0001);
    rd(`REG_GUARD, 16'h0005);
    expect_ser("OK\r");
    escape(8'h31, 1'b0);
    wait_mode(1'b1);
    expect_ser("ERROR\r");
    line("ATZZ\r");
    expect_ser("OK\r");
    line("atap1,GT0x5\r");
    expect_ser("OK\r");
    line("ATCN\r");
    wait_mode(1'b0);
    check({15'h0000, o_api_mode}, 16'h0001);
    ser_q.push_back(8'hA5);
    ser_q.push_back(8'hC3);
    ser_q.push_back(8'h77);
    rf_in(8'h77, 1'b1, 16'hA5C3);
    // a later byte of the same frame carries no address
    ser_q.push_back(8'h66);
    rf_in(8'h66, 1'b0, 16'hA5C3);
    // settings still change with a long command pending
    busy <= 1'b1;
    wr(`REG_GUARD, 16'h0006);
    rd(`REG_GUARD, 16'h0006);
    busy <= 1'b0;
    expect_ser("OK\r");
    escape(8'h31, 1'b0);
    wait_mode(1'b1);
    idle(300);
    check({15'h0000, o_cmd_mode}, 16'h0001);
    wait_mode(1'b0);
    wr(`REG_CTRL, 16'h0000);
    // a byte right after the escapes cancels entry; all bytes reach the radio
    check(16'(rf_q.size()), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'h0D : 8'h78;
      idle(40);
      repeat (3) rf_q.push_back(8'h31);
      rf_q.push_back(b);
      repeat (3) host.send(8'h31, 1'b0);
      host.send(b, 1'b0);
      idle(40);
      check({15'h0000, o_cmd_mode}, 16'h0000);
    end
    repeat (3) rf_q.push_back(8'h31);
    escape(8'h31, 1'b1);
    check({15'h0000, o_cmd_mode}, 16'h0000);
    wr(`REG_CTRL, 16'h0002);
    expect_ser("OK\r");
    escape(8'h31, 1'b1);
    wait_mode(1'b1);
    // command mode refuses a setting while a long command is pending
    busy <= 1'b1;
    expect_ser("ERROR\r");
    line("ATGT7\r");
    busy <= 1'b0;
    expect_ser("OK\r");
    line("ATCN\r");
    wait_mode(1'b0);
    rd(`REG_GUARD, 16'h0006);
    idle(40);
    check(16'(rf_q.size() + ser_q.size() + rd_exp.size()), 16'h0000);
    results();
  end
endmodule
